/* File: pkg/sr_lowpower_consts.vh */
// timing constants for the rectifier low-consumption mode control
`ifndef SR_LOWPOWER_CONSTS_VH
`define SR_LOWPOWER_CONSTS_VH
// clock period in ns
`define CLK_PERIOD_NS 40
// fixed sleep margin in ns, cycles rounded up
`define SLEEP_MARGIN_NS 300
`define SLEEP_MARGIN_CYC ((`SLEEP_MARGIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// sleep-out factor 1.2 written as 12/10
`define SLEEP_OUT_NUM 12
`define SLEEP_OUT_DEN 10
// default minimum on-time, maximum on-time and stop timeout in cycles
`define MIN_ON_DEFAULT 16'h0019
`define MAX_ON_DEFAULT 16'h0271
`define STOP_TIMEOUT_DEFAULT 16'h0fa0
// width of all time counters
`define TIME_W 16
// start-up option sensing lasts this many switching cycles
`define STRAP_CYCLES 3'h5
`endif

/* File: hdl/sat_counter.v */
// saturating cycle counter with synchronous clear
`timescale 1ns/1ps
module sat_counter #(
  parameter W = 16
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // control
  input wire clear,
  input wire run,
  // count
  output reg [W-1:0] count
);
  always @(posedge clk) begin
    if (srst || clear) begin
      count <= {W{1'b0}};
    end else if (run && (count != {W{1'b1}})) begin
      count <= count + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

/* File: hdl/sr_lowpower_ctrl.v */
// low-consumption mode control and gate timing for a synchronous rectifier
//
// Functional notes
// RL1: sleep when conduction at most min plus 300ns
// RL2: wake when conduction exceeds 1.2 min plus 300ns
// RL3: conduction timed from drain fall to rise
// RL4: state changes after a single qualifying cycle
// RL5: burst when drain high beyond stop timeout
// RL6: sleep-out at first drain fall after burst
// RL7: first resumed cycle drives no gate
// RL8: second resumed cycle drives exactly min on-time
// RL9: burst from sleep needs one sleep-out cycle
// RL10: close aux switch below switchover until turn-on
// RL11: gate pulse capped at maximum on-time
// RL12: after option sensing start asleep, wake by threshold
// RL13: times are cycle-count parameters
`timescale 1ns/1ps
`include "sr_lowpower_consts.vh"
module sr_lowpower_ctrl #(
  parameter [`TIME_W-1:0] MIN_ON = `MIN_ON_DEFAULT,
  parameter [`TIME_W-1:0] MAX_ON = `MAX_ON_DEFAULT,
  parameter [`TIME_W-1:0] STOP_TIMEOUT = `STOP_TIMEOUT_DEFAULT
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // drain sense comparator: high while drain above arming threshold
  input wire drain_sense,
  // supply comparators
  input wire supply_below_switchover,
  input wire supply_above_turn_on,
  // gate drive and auxiliary supply switch
  output reg gate_drive,
  output reg aux_switch_on,
  // mode status
  output reg sleep_mode,
  output reg burst_mode,
  output reg run_mode
);
  // ****************************************
  // thresholds
  // ****************************************
  // see RL13
  // the margin is rounded up, so a borderline cycle still counts as short
  localparam [31:0] MARGIN_WIDE = `SLEEP_MARGIN_CYC;
  localparam [`TIME_W-1:0] MARGIN = MARGIN_WIDE[`TIME_W-1:0];
  localparam [`TIME_W-1:0] SLEEP_IN_THR = MIN_ON + MARGIN; // see RL1
  localparam [31:0] OUT_WIDE = (MIN_ON * `SLEEP_OUT_NUM) / `SLEEP_OUT_DEN;
  localparam [`TIME_W-1:0] SLEEP_OUT_THR = OUT_WIDE[`TIME_W-1:0] + MARGIN; // see RL2

  // states, one-hot
  localparam [5:0] ST_STRAP = 6'h01;
  localparam [5:0] ST_SLEEP = 6'h02;
  localparam [5:0] ST_RUN = 6'h04;
  localparam [5:0] ST_BURST = 6'h08;
  localparam [5:0] ST_SKIP = 6'h10;
  localparam [5:0] ST_MINPULSE = 6'h20;

  // ****************************************
  // input synchronisers
  // ****************************************
  reg [1:0] ds_sync;
  reg [1:0] sw_sync;
  reg [1:0] on_sync;
  reg ds_prev;
  always @(posedge clk) begin
    if (srst) begin
      ds_sync <= 2'h3;
      sw_sync <= 2'h0;
      on_sync <= 2'h0;
      ds_prev <= 1'b1;
    end else begin
      ds_sync <= {ds_sync[0], drain_sense};
      sw_sync <= {sw_sync[0], supply_below_switchover};
      on_sync <= {on_sync[0], supply_above_turn_on};
      ds_prev <= ds_sync[1];
    end
  end
  wire ds = ds_sync[1];
  wire ds_fall = ds_prev && !ds;
  wire ds_rise = !ds_prev && ds;

  // ****************************************
  // conduction and stop timers
  // ****************************************
  wire [`TIME_W-1:0] cond_count;
  wire [`TIME_W-1:0] high_count;
  // conduction counted while drain is low; cleared on the falling edge
  sat_counter #(.W(`TIME_W)) u_cond (
    .clk(clk),
    .srst(srst),
    .clear(ds_fall),
    .run(!ds),
    .count(cond_count)
  ); // see RL3
  sat_counter #(.W(`TIME_W)) u_high (
    .clk(clk),
    .srst(srst),
    .clear(!ds),
    .run(ds),
    .count(high_count)
  );
  // the counter misses the falling-edge cycle, so one is added back; saturation holds the top value
  wire cond_full = (cond_count == {`TIME_W{1'b1}});
  reg [`TIME_W-1:0] cond_meas;
  always @* begin
    if (cond_full) begin
      cond_meas = cond_count;
    end else begin
      cond_meas = cond_count + {{(`TIME_W-1){1'b0}}, 1'b1};
    end
  end
  wire cond_long = ds_rise && (cond_meas > SLEEP_OUT_THR); // see RL2
  wire cond_short = ds_rise && (cond_meas <= SLEEP_IN_THR); // see RL1
  wire stop_seen = ds && (high_count > STOP_TIMEOUT); // see RL5

  // ****************************************
  // mode state machine
  // ****************************************
  reg [5:0] state;
  reg [5:0] next_state;
  reg [2:0] strap_cnt;
  reg burst_from_sleep;
  reg next_burst_from_sleep;
  always @* begin
    next_state = state;
    next_burst_from_sleep = burst_from_sleep;
    case (state)
      ST_STRAP: begin
        if (ds_rise && strap_cnt == `STRAP_CYCLES - 3'h1) begin
          next_state = ST_SLEEP; // see RL12
        end
      end
      ST_SLEEP: begin
        if (stop_seen) begin
          next_state = ST_BURST;
          next_burst_from_sleep = 1'b1;
        end else if (cond_long) begin
          next_state = ST_RUN; // see RL4
        end
      end
      ST_RUN: begin
        if (stop_seen) begin
          next_state = ST_BURST;
          next_burst_from_sleep = 1'b0;
        end else if (cond_short) begin
          next_state = ST_SLEEP; // see RL1
        end
      end
      ST_BURST: begin
        if (ds_fall) begin
          // from sleep the normal wake threshold applies
          next_state = burst_from_sleep ? ST_SLEEP : ST_SKIP; // see RL6
          if (burst_from_sleep) begin
            next_state = ST_SLEEP; // see RL9
          end
        end
      end
      ST_SKIP: begin
        if (stop_seen) begin
          next_state = ST_BURST;
        end else if (ds_fall) begin
          next_state = ST_MINPULSE; // see RL7
        end
      end
      ST_MINPULSE: begin
        if (stop_seen) begin
          next_state = ST_BURST;
        end else if (ds_rise) begin
          next_state = ST_RUN; // see RL8
        end
      end
      default: begin
        next_state = ST_STRAP;
      end
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      state <= ST_STRAP;
      burst_from_sleep <= 1'b0;
    end else begin
      state <= next_state;
      burst_from_sleep <= next_burst_from_sleep;
    end
  end

  // ****************************************
  // option sensing cycle count
  // ****************************************
  // counts drain rises only while sensing; it is not needed afterwards
  always @(posedge clk) begin
    if (srst) begin
      strap_cnt <= 3'h0;
    end else if (state == ST_STRAP && ds_rise) begin
      strap_cnt <= strap_cnt + 3'h1; // see RL12
    end
  end

  // ****************************************
  // gate drive
  // ****************************************
  // pulse starts the cycle after drain fall and ends at drain rise, max or min limit
  reg gate_en;
  reg [`TIME_W-1:0] pulse_cnt;
  // cycles driven so far, counting the one on the pin now; one bit wider so a saturated count cannot wrap
  wire [`TIME_W:0] pulse_done = {1'b0, pulse_cnt} + {{`TIME_W{1'b0}}, gate_drive};
  wire [`TIME_W:0] max_lim = {1'b0, MAX_ON};
  wire [`TIME_W:0] min_lim = {1'b0, MIN_ON};
  // the fall cycle itself never drives: the count of the last pulse still stands there
  wire pulse_ok = !ds && !ds_fall;
  always @* begin
    gate_en = 1'b0;
    case (state)
      ST_RUN: begin
        gate_en = pulse_ok && (pulse_done < max_lim); // see RL11
      end
      ST_MINPULSE: begin
        gate_en = pulse_ok && (pulse_done < min_lim); // see RL8
      end
      ST_SKIP: begin
        gate_en = 1'b0; // see RL7
      end
      default: begin
        gate_en = 1'b0;
      end
    endcase
  end
  always @(posedge clk) begin
    if (srst) begin
      pulse_cnt <= {`TIME_W{1'b0}};
      gate_drive <= 1'b0;
    end else begin
      if (ds_fall) begin
        pulse_cnt <= {`TIME_W{1'b0}};
      end else if (gate_drive && pulse_cnt != {`TIME_W{1'b1}}) begin
        pulse_cnt <= pulse_cnt + {{(`TIME_W-1){1'b0}}, 1'b1};
      end
      // no drive in option sensing, sleep, burst or skip states
      gate_drive <= gate_en;
    end
  end

  // ****************************************
  // mode status decode
  // ****************************************
  // flags follow the next state so they change on the same edge as the state
  reg next_sleep;
  reg next_burst;
  reg next_run;
  always @* begin
    next_sleep = 1'b0;
    next_burst = 1'b0;
    next_run = 1'b0;
    case (next_state)
      ST_SLEEP: begin
        next_sleep = 1'b1;
      end
      ST_BURST: begin
        next_burst = 1'b1;
      end
      ST_RUN, ST_SKIP, ST_MINPULSE: begin
        next_run = 1'b1;
      end
      default: begin
        next_run = 1'b0;
      end
    endcase
  end

  // ****************************************
  // auxiliary supply switch and status
  // ****************************************
  always @(posedge clk) begin
    if (srst) begin
      aux_switch_on <= 1'b0;
      sleep_mode <= 1'b0;
      burst_mode <= 1'b0;
      run_mode <= 1'b0;
    end else begin
      // hysteresis: close below switchover, open once turn-on level is reached
      if (sw_sync[1]) begin
        aux_switch_on <= 1'b1; // see RL10
      end else if (on_sync[1]) begin
        aux_switch_on <= 1'b0;
      end
      sleep_mode <= next_sleep;
      burst_mode <= next_burst;
      run_mode <= next_run;
    end
  end
endmodule

/* File: bench/sr_lowpower_ctrl_properties.sv */
// checker for the low-consumption mode control
`timescale 1ns/1ps
module sr_lowpower_props #(
  parameter [15:0] MIN_ON = 16'h0004,
  parameter [15:0] MAX_ON = 16'h0028,
  parameter [15:0] STOP_TIMEOUT = 16'h003c
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // sensed inputs
  input wire drain_sense,
  input wire supply_below_switchover,
  input wire supply_above_turn_on,
  // outputs
  input wire gate_drive,
  input wire aux_switch_on,
  input wire sleep_mode,
  input wire burst_mode,
  input wire run_mode
);
  reg [15:0] glen = 16'h0000;
  reg [15:0] dhigh = 16'h0000;
  reg pend = 1'b0;
  // pend marks the resume pulse that must be exactly the minimum width
  always @(posedge clk) begin
    glen <= gate_drive ? glen + 16'h0001 : 16'h0000;
    dhigh <= drain_sense ? dhigh + 16'h0001 : 16'h0000;
    pend <= srst ? 1'b0 : ($fell(burst_mode) && run_mode) ? 1'b1 : ($fell(gate_drive) ? 1'b0 : pend);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_one_mode: assert property ($onehot0({sleep_mode, burst_mode, run_mode})) else $error("modes overlap");
  a_strap_quiet: assert property (!(sleep_mode || burst_mode || run_mode) |-> !gate_drive)
    else $error("gate during option sensing");
  a_sleep_quiet: assert property (sleep_mode && $past(sleep_mode) |-> !gate_drive)
    else $error("gate while asleep");
  a_burst_quiet: assert property (burst_mode && $past(burst_mode) |-> !gate_drive)
    else $error("gate in burst");
  a_gate_cap: assert property (glen <= MAX_ON) else $error("gate pulse too long");
  a_burst_entry: assert property ((run_mode || sleep_mode) && dhigh == STOP_TIMEOUT + 16'h0003 |-> ##[1:4] burst_mode)
    else $error("no burst after stop");
  a_skip_first: assert property ($fell(burst_mode) |-> !gate_drive [*8]) else $error("gate in skip cycle");
  a_min_pulse: assert property (pend && $fell(gate_drive) |-> glen == MIN_ON) else $error("resume width");
  a_aux_close: assert property (supply_below_switchover [*5] |-> aux_switch_on) else $error("aux open");
  a_aux_open: assert property ((supply_above_turn_on && !supply_below_switchover) [*5] |-> !aux_switch_on)
    else $error("aux stuck");
  c_resume: cover property (pend && $fell(gate_drive));
  c_cap: cover property (glen == MAX_ON);
  c_burst: cover property ($rose(burst_mode));
endmodule

/* File: bench/sr_stage.sv */
// drain-sense model of the rectifier switch
`timescale 1ns/1ps
module sr_stage (
  // clock
  input wire clk,
  // en low stops switching, low_len is conduction in cycles
  input wire en,
  input wire [7:0] low_len,
  // comparator level
  output reg drain_sense
);
  reg [7:0] cnt = 8'h00;
  initial drain_sense = 1'b1;
  // drain sits high while the primary pauses
  always @(posedge clk) begin
    if (!en && drain_sense) begin
      cnt <= 8'h00;
    end else if (cnt == 8'h00) begin
      drain_sense <= ~drain_sense;
      cnt <= drain_sense ? low_len - 8'h01 : 8'h0f;
    end else begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule

/* File: bench/sr_lowpower_ctrl_tb.sv */
// testbench for the low-consumption mode control
`timescale 1ns/1ps
module sr_lowpower_ctrl_tb;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg en = 1'b0;
  reg [7:0] low_len = 8'h1e;
  reg below = 1'b0;
  reg above = 1'b0;
  wire drain_sense, gate_drive, aux_switch_on, sleep_mode, burst_mode, run_mode;
  integer n_fail = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer n;
  always #20 clk = ~clk;
  sr_stage far (.clk(clk), .en(en), .low_len(low_len), .drain_sense(drain_sense));
  sr_lowpower_ctrl #(.MIN_ON(16'h000a), .MAX_ON(16'h0028), .STOP_TIMEOUT(16'h003c)) dut (.clk(clk), .srst(srst),
    .drain_sense(drain_sense), .supply_below_switchover(below), .supply_above_turn_on(above),
    .gate_drive(gate_drive), .aux_switch_on(aux_switch_on), .sleep_mode(sleep_mode), .burst_mode(burst_mode),
    .run_mode(run_mode));
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  // gate cycles in one switching period from a drain fall
  task window;
    begin
      @(negedge drain_sense);
      n = 0;
      repeat (low_len + 16) @(posedge clk) n = n + gate_drive;
    end
  endtask
  task set_low(input [7:0] v);
    begin
      @(posedge clk) low_len <= v;
      repeat (3) window;
    end
  endtask
  task stop_go(input [7:0] v);
    begin
      @(posedge clk) en <= 1'b0;
      repeat (200) @(posedge clk);
      chk(burst_mode, 1);
      low_len <= v;
      en <= 1'b1;
    end
  endtask
  task give_verdict;
    begin
      $display("fails %0d compares %0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    en <= 1'b1;
    repeat (3) window;
    chk(n, 0);
    chk(run_mode, 0);
    repeat (6) window;
    chk(run_mode, 1);
    set_low(8'h3c);
    chk(n, 40);
    stop_go(8'h1e);
    window;
    chk(n, 0);
    window;
    chk(n, 10);
    set_low(8'h12);
    chk(sleep_mode, 1);
    chk(n, 0);
    set_low(8'h14);
    chk(sleep_mode, 1);
    set_low(8'h15);
    chk(run_mode, 1);
    set_low(8'h12);
    stop_go(8'h12);
    repeat (3) window;
    chk(n, 0);
    chk(sleep_mode, 1);
    set_low(8'h1e);
    chk(run_mode, 1);
    below <= 1'b1;
    repeat (6) @(posedge clk);
    chk(aux_switch_on, 1);
    below <= 1'b0;
    repeat (6) @(posedge clk);
    chk(aux_switch_on, 1);
    above <= 1'b1;
    repeat (6) @(posedge clk);
    chk(aux_switch_on, 0);
    give_verdict;
  end
endmodule
bind sr_lowpower_ctrl sr_lowpower_props #(.MIN_ON(MIN_ON), .MAX_ON(MAX_ON), .STOP_TIMEOUT(STOP_TIMEOUT)) props (
  .clk(clk), .srst(srst), .drain_sense(drain_sense), .supply_below_switchover(supply_below_switchover),
  .supply_above_turn_on(supply_above_turn_on), .gate_drive(gate_drive), .aux_switch_on(aux_switch_on),
  .sleep_mode(sleep_mode), .burst_mode(burst_mode), .run_mode(run_mode));
